// ---- acs_device_end.sv ----
// channel sequencer master module: address decode, mode latch, channel counter
//
// How it works
// - respond only to own octal 40-77 address
// - one address drives master plus fifteen slaves
// - sequential mode steps from channel 1 upward
// - random mode selects whatever channel is written
// - split channel into two four-bit select codes
// - exactly one switch closed at a time
// - end of scan when count reaches final
// - function 02 sequential, 01 random
// - capture channel code on data-out transfer
// - sequential: only final code sent, rest generated
// - random: one transfer per new channel
// - function 0 random plus block transfer enable
// - sense code 0 returns end of scan
// - end of scan offered as interrupt request
// - host waits about 10 us settling
// - random: settle from each transfer to start
// - sequential: advance at each conversion start
// - counter advances on busy rising edge
// - after end of scan, next conversion restarts
// - low nibble switch pair, high nibble module
// - mode holds until a sequential, random or bic order, or reset
//
// Our own choices: the APB slave port and the register offsets.
`include "acs_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module acs_device_end (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// programmed i/o bus
	acs_bus_if.device bus,
	// address strap and converter busy pins
	input wire logic [5:0] addr_strap,
	input wire logic conv_busy,
	// select codes to master and expansion modules
	output logic [3:0] sel_switch,
	output logic [3:0] sel_module,
	output logic [15:0] switch_onehot,
	output logic [15:0] module_onehot,
	output logic blanking,
	// status
	output logic eos_irq,
	output logic seq_mode,
	output logic bic_enabled,
	output logic addr_ok
);
	import acs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [5:0] strap_s1;
	logic [5:0] strap_s2;
	logic busy_s1;
	logic busy_s2;
	logic busy_s3;

	// two flops on each pin plus a third on busy; the busy edge compares the second and third stages
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_s1 <= 6'h00;
			strap_s2 <= 6'h00;
			busy_s1 <= 1'b0;
			busy_s2 <= 1'b0;
			busy_s3 <= 1'b0;
		end else begin
			strap_s1 <= addr_strap;
			strap_s2 <= strap_s1;
			busy_s1 <= conv_busy;
			busy_s2 <= busy_s1;
			busy_s3 <= busy_s2;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// address decode and conversion clock

	logic strap_valid;
	logic hit;
	logic conv_clk;

	// a strap outside octal 40-77 leaves the device deaf to every order
	assign strap_valid = strap_s2[`ACS_ADDR_BASE_BIT];
	// one match serves the whole group; slaves only see select codes
	assign hit = strap_valid && (bus.io_addr == strap_s2);
	// converter busy rising marks each conversion start
	assign conv_clk = busy_s2 && !busy_s3;

	////////////////////////////////////////////////////////////////////////
	// control state

	logic mode_seq;
	logic bic_en;
	logic [7:0] final_ch;
	logic [7:0] chan;
	logic eos;
	logic sense_q;
	logic blank_q;
	logic [15:0] sw_q;
	logic [15:0] mod_q;
	logic ok_q;
	logic next_mode_seq;
	logic next_bic_en;
	logic [7:0] next_final_ch;
	logic [7:0] next_chan;
	logic next_eos;
	logic next_sense_q;
	logic next_blank_q;
	logic [15:0] next_sw_q;
	logic [15:0] next_mod_q;
	logic [7:0] chan_inc;
	logic load;

	assign chan_inc = chan + 8'h01;

	// any data-out source is taken; block transfers only once enabled
	assign load = hit && (bus.dto_stb || (bus.bic_stb && bic_en));

	// next-state: orders first, then loads, then conversion steps
	always_comb begin
		next_mode_seq = mode_seq;
		next_bic_en = bic_en;
		next_final_ch = final_ch;
		next_chan = chan;
		next_eos = eos;
		next_sense_q = 1'b0;
		next_blank_q = 1'b0;
		if (hit && bus.exc_stb) begin
			case (bus.io_func)
				`ACS_FN_SEQ: begin
					next_mode_seq = 1'b1;
					next_bic_en = 1'b0;
				end
				`ACS_FN_RANDOM: begin
					next_mode_seq = 1'b0;
					next_bic_en = 1'b0;
				end
				`ACS_FN_BIC: begin
					next_mode_seq = 1'b0;
					next_bic_en = 1'b1;
				end
				default: begin
					next_mode_seq = mode_seq;
				end
			endcase
		end else if (load) begin
			next_blank_q = 1'b1;
			next_eos = 1'b0;
			if (mode_seq) begin
				// only the final code arrives; the scan starts at channel 1
				next_final_ch = bus.io_data;
				next_chan = `ACS_FIRST_CH;
			end else begin
				next_final_ch = bus.io_data;
				next_chan = bus.io_data;
			end
		end else if (conv_clk && mode_seq) begin
			next_blank_q = 1'b1;
			if (eos) begin
				// a finished scan wraps back to channel 1 on the next start
				next_chan = `ACS_FIRST_CH;
				next_eos = (final_ch == `ACS_FIRST_CH);
			end else begin
				next_chan = chan_inc;
				next_eos = (chan_inc == final_ch);
			end
		end
		// sense line answers only the end of scan code at this address
		if (hit && bus.sen_stb && (bus.io_func == `ACS_SENSE_EOS)) begin
			next_sense_q = eos && mode_seq;
		end
		// decoded so a single switch pair and a single module are on
		next_sw_q = 16'h0001 << next_chan[3:0];
		next_mod_q = 16'h0001 << next_chan[7:4];
	end

	// registers; sequential mode after reset, as the mode latch clears to it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_seq <= 1'b1;
			bic_en <= 1'b0;
			final_ch <= 8'h00;
			chan <= `ACS_FIRST_CH;
			eos <= 1'b0;
			sense_q <= 1'b0;
			blank_q <= 1'b0;
			sw_q <= 16'h0002;
			mod_q <= 16'h0001;
			ok_q <= 1'b0;
		end else begin
			mode_seq <= next_mode_seq;
			bic_en <= next_bic_en;
			final_ch <= next_final_ch;
			chan <= next_chan;
			eos <= next_eos;
			sense_q <= next_sense_q;
			blank_q <= next_blank_q;
			sw_q <= next_sw_q;
			mod_q <= next_mod_q;
			ok_q <= strap_valid;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs from flops; eos_irq is the and of the eos and mode flops

	// both nibbles go to every module of the group
	assign sel_switch = chan[3:0];
	assign sel_module = chan[7:4];
	assign switch_onehot = sw_q;
	assign module_onehot = mod_q;
	// blanking opens the old switch before the new one closes
	assign blanking = blank_q;
	// eos is only meaningful in sequential mode, so gate it there
	assign eos_irq = eos && mode_seq;
	assign seq_mode = mode_seq;
	assign bic_enabled = bic_en;
	assign addr_ok = ok_q;
	assign bus.sense_ret = sense_q;

endmodule : acs_device_end
`default_nettype wire

// ---- acs_regs.svh ----
// offsets, field positions, reset values and timing counts of the channel sequencer
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// host end apb register offsets (byte addresses)
`define ACS_OFF_CMD 12'h000
`define ACS_OFF_ADDR 12'h004
`define ACS_OFF_STAT 12'h008

// command register fields
`define ACS_CMD_KIND_LSB 0
`define ACS_CMD_FUNC_LSB 2
`define ACS_CMD_DATA_LSB 8

// status register bits
`define ACS_STAT_BUSY 0
`define ACS_STAT_SENSE 1
`define ACS_STAT_SETTLED 2

// control function codes carried with the device address
`define ACS_FN_BIC 2'h0
`define ACS_FN_RANDOM 2'h1
`define ACS_FN_SEQ 2'h2
`define ACS_SENSE_EOS 2'h0

// device address: octal 40 through 77 all have bit 5 set
`define ACS_ADDR_RST 6'h20
`define ACS_ADDR_BASE_BIT 5
`define ACS_FIRST_CH 8'h01

// settling time before a conversion may start
`define ACS_CLK_NS 10
`define ACS_SETTLE_NS 10000
`define ACS_SETTLE_CYC ((`ACS_SETTLE_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)

`endif

// ---- acs_pkg.sv ----
// types shared by both ends of the channel sequencer
package acs_pkg;

	// order kinds that the host end can place on the i/o bus
	typedef enum logic [1:0] {
		acs_k_exc = 2'h0,
		acs_k_sen = 2'h1,
		acs_k_dto = 2'h2,
		acs_k_bic = 2'h3
	} acs_kind_t;

	// host end sequencer, gray coded
	typedef enum logic [1:0] {
		acs_h_idle = 2'b00,
		acs_h_drive = 2'b01,
		acs_h_sample = 2'b11,
		acs_h_wait = 2'b10
	} acs_hstate_t;

	// data-out sources: accumulator a, accumulator b, memory
	typedef enum logic [1:0] {
		acs_src_acc_a = 2'h0,
		acs_src_acc_b = 2'h1,
		acs_src_mem = 2'h2
	} acs_src_t;

endpackage : acs_pkg

// ---- acs_bus_if.sv ----
// programmed i/o bus between the host end and the sequencer end
`timescale 1ns/1ps
`default_nettype none
interface acs_bus_if;
	import acs_pkg::*;
	logic [5:0] io_addr;
	logic [1:0] io_func;
	logic exc_stb;
	logic sen_stb;
	logic dto_stb;
	logic bic_stb;
	acs_src_t dto_src;
	logic [7:0] io_data;
	logic sense_ret;

	modport host (
		output io_addr, io_func, exc_stb, sen_stb, dto_stb, bic_stb, dto_src, io_data,
		input sense_ret
	);
	modport device (
		input io_addr, io_func, exc_stb, sen_stb, dto_stb, bic_stb, dto_src, io_data,
		output sense_ret
	);
endinterface : acs_bus_if
`default_nettype wire

// ---- acs_host_end.sv ----
// host end: apb registers that turn software orders into i/o bus cycles
`include "acs_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module acs_host_end (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// programmed i/o bus
	acs_bus_if.host bus
);
	import acs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// apb access decode

	logic access;
	logic wr_cmd;
	logic mapped;
	acs_hstate_t st;
	acs_hstate_t next_st;

	// pready is a flop raised in the access phase: one wait-free access
	assign access = psel && penable && pready;
	assign mapped = (paddr == `ACS_OFF_CMD) || (paddr == `ACS_OFF_ADDR) ||
		(paddr == `ACS_OFF_STAT);
	// a command while one is still on the bus is refused
	assign wr_cmd = access && pwrite && (paddr == `ACS_OFF_CMD) && (st == acs_h_idle);

	////////////////////////////////////////////////////////////////////////
	// registers and bus sequencer

	logic [5:0] dev_addr;
	acs_kind_t kind;
	logic [1:0] func;
	logic [7:0] data;
	logic sense_res;
	logic [9:0] settle;
	logic [5:0] next_dev_addr;
	acs_kind_t next_kind;
	logic [1:0] next_func;
	logic [7:0] next_data;
	logic next_sense_res;
	logic [9:0] next_settle;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic next_exc;
	logic next_sen;
	logic next_dto;
	logic next_bic;

	// next values of the register file, the sequencer and the bus strobes
	always_comb begin
		next_dev_addr = dev_addr;
		next_kind = kind;
		next_func = func;
		next_data = data;
		next_sense_res = sense_res;
		next_settle = (settle != 10'h000) ? settle - 10'h001 : settle;
		next_st = st;
		next_exc = 1'b0;
		next_sen = 1'b0;
		next_dto = 1'b0;
		next_bic = 1'b0;
		next_pready = psel && !penable;
		next_pslverr = psel && !penable && (!mapped ||
			(pwrite && (paddr == `ACS_OFF_CMD) && (st != acs_h_idle)));
		next_prdata = 32'h0000_0000;
		if (psel && !penable && !pwrite) begin
			case (paddr)
				`ACS_OFF_ADDR: next_prdata = {26'h0, dev_addr};
				`ACS_OFF_STAT: next_prdata = {29'h0, (settle == 10'h000), sense_res,
					(st != acs_h_idle)};
				default: next_prdata = 32'h0000_0000;
			endcase
		end
		if (access && pwrite && (paddr == `ACS_OFF_ADDR)) begin
			next_dev_addr = pwdata[5:0];
		end
		case (st)
			acs_h_idle: begin
				if (wr_cmd) begin
					next_kind = acs_kind_t'(pwdata[`ACS_CMD_KIND_LSB +: 2]);
					next_func = pwdata[`ACS_CMD_FUNC_LSB +: 2];
					next_data = pwdata[`ACS_CMD_DATA_LSB +: 8];
					next_st = acs_h_drive;
				end
			end
			acs_h_drive: begin
				// one strobe cycle; data transfers restart the settling wait
				next_exc = (kind == acs_k_exc);
				next_sen = (kind == acs_k_sen);
				next_dto = (kind == acs_k_dto);
				next_bic = (kind == acs_k_bic);
				if ((kind == acs_k_dto) || (kind == acs_k_bic)) begin
					next_settle = 10'(`ACS_SETTLE_CYC);
				end
				next_st = acs_h_sample;
			end
			acs_h_sample: begin
				// the device flop is loaded at the end of this cycle, so wait one more
				next_st = acs_h_wait;
			end
			acs_h_wait: begin
				// the device answers the sense one cycle after the strobe
				if (kind == acs_k_sen) begin
					next_sense_res = bus.sense_ret;
				end
				next_st = acs_h_idle;
			end
			default: next_st = acs_h_idle;
		endcase
	end

	// register stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dev_addr <= `ACS_ADDR_RST;
			kind <= acs_k_exc;
			func <= 2'h0;
			data <= 8'h00;
			sense_res <= 1'b0;
			settle <= 10'h000;
			st <= acs_h_idle;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			bus.exc_stb <= 1'b0;
			bus.sen_stb <= 1'b0;
			bus.dto_stb <= 1'b0;
			bus.bic_stb <= 1'b0;
			bus.io_addr <= 6'h00;
			bus.io_func <= 2'h0;
			bus.io_data <= 8'h00;
			bus.dto_src <= acs_src_acc_a;
		end else begin
			dev_addr <= next_dev_addr;
			kind <= next_kind;
			func <= next_func;
			data <= next_data;
			sense_res <= next_sense_res;
			settle <= next_settle;
			st <= next_st;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			bus.exc_stb <= next_exc;
			bus.sen_stb <= next_sen;
			bus.dto_stb <= next_dto;
			bus.bic_stb <= next_bic;
			bus.io_addr <= dev_addr;
			bus.io_func <= func;
			bus.io_data <= data;
			bus.dto_src <= (kind == acs_k_bic) ? acs_src_mem : acs_src_t'(func);
		end
	end

endmodule : acs_host_end
`default_nettype wire

// ---- acs_checker.sv ----
// assertions on the i/o bus between host end and sequencer end
`timescale 1ns/1ps
`default_nettype none
module acs_checker (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// programmed i/o bus
	input wire logic [5:0] io_addr,
	input wire logic [1:0] io_func,
	input wire logic exc_stb,
	input wire logic sen_stb,
	input wire logic dto_stb,
	input wire logic bic_stb,
	input wire acs_pkg::acs_src_t dto_src,
	input wire logic [7:0] io_data,
	input wire logic sense_ret
);
	import acs_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////
	// a sense answer needs an end-of-scan sense at a valid address
	sequence s_ask;
		sen_stb && io_func == 2'h0 && io_addr[5];
	endsequence
	property p_sense_cause;
		sense_ret |-> $past(sen_stb && io_func == 2'h0 && io_addr[5]);
	endproperty
	a_sense_cause: assert property (p_sense_cause) else $error("stray sense");
	property p_sense_pulse;
		s_ask ##1 sense_ret |=> !sense_ret;
	endproperty
	a_sense_pulse: assert property (p_sense_pulse) else $error("long sense");
	property p_sense_quiet;
		sen_stb && io_func != 2'h0 |=> !sense_ret;
	endproperty
	a_sense_quiet: assert property (p_sense_quiet) else $error("bad code");
	// exchange, data-out and block orders are single-cycle strobes, never two orders at once
	property p_exc_pulse;
		exc_stb |=> !exc_stb;
	endproperty
	a_exc_pulse: assert property (p_exc_pulse) else $error("exc long");
	property p_dto_pulse;
		dto_stb |=> !dto_stb;
	endproperty
	a_dto_pulse: assert property (p_dto_pulse) else $error("dto long");
	property p_bic_pulse;
		bic_stb |=> !bic_stb;
	endproperty
	a_bic_pulse: assert property (p_bic_pulse) else $error("bic long");
	property p_one_order;
		$onehot0({exc_stb, sen_stb, dto_stb, bic_stb});
	endproperty
	a_one_order: assert property (p_one_order) else $error("two orders");
	// block transfers always come from memory
	property p_bic_src;
		bic_stb |-> dto_src == acs_src_mem;
	endproperty
	a_bic_src: assert property (p_bic_src) else $error("bic source");
	property p_dto_src;
		dto_stb |-> dto_src != 2'h3;
	endproperty
	a_dto_src: assert property (p_dto_src) else $error("dto source");
	c_top: cover property (dto_stb && io_data == 8'hFF);
endmodule : acs_checker
`default_nettype wire

// ---- analog_channel_sequencer_tb.sv ----
// self-checking bench for both ends of the channel sequencer
`include "acs_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module analog_channel_sequencer_tb;
	import acs_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [5:0] addr_strap;
	logic conv_busy = 1'b0;
	logic [3:0] sel_switch;
	logic [3:0] sel_module;
	logic [15:0] switch_onehot;
	logic [15:0] module_onehot;
	logic blanking;
	logic eos_irq;
	logic seq_mode;
	logic bic_enabled;
	logic addr_ok;
	logic [31:0] rd;
	logic err;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #5 pclk = ~pclk;
	////////////////////////////////////////////////////////////////////////
	acs_bus_if bus_if ();
	acs_host_end acs_host_end_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .bus(bus_if.host));
	acs_device_end acs_device_end_inst (.pclk, .presetn, .bus(bus_if.device), .addr_strap,
		.conv_busy, .sel_switch, .sel_module, .switch_onehot, .module_onehot, .blanking,
		.eos_irq, .seq_mode, .bic_enabled, .addr_ok);
	acs_checker acs_checker_inst (.pclk, .presetn, .io_addr(bus_if.io_addr),
		.io_func(bus_if.io_func), .exc_stb(bus_if.exc_stb), .sen_stb(bus_if.sen_stb),
		.dto_stb(bus_if.dto_stb), .bic_stb(bus_if.bic_stb), .dto_src(bus_if.dto_src),
		.io_data(bus_if.io_data), .sense_ret(bus_if.sense_ret));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	function automatic logic [15:0] oh(input logic [3:0] n);
		return 16'h0001 << n;
	endfunction : oh
	task automatic chk_sel(input logic [7:0] c);
		chk("sel_switch", sel_switch, c[3:0]);
		chk("sel_module", sel_module, c[7:4]);
		chk("switch_onehot", switch_onehot, oh(c[3:0]));
		chk("module_onehot", module_onehot, oh(c[7:4]));
	endtask : chk_sel
	// one apb transfer; an idle edge after it keeps psel single-driven per step
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// command then poll busy, so no command is refused for overlap
	task automatic order(input logic [1:0] k, input logic [1:0] f, input logic [7:0] d);
		int n;
		apb(1'b1, `ACS_OFF_CMD, {16'h0, d, 4'h0, f, k});
		n = 0;
		do begin
			apb(1'b0, `ACS_OFF_STAT, 32'h0);
			n++;
		end while (rd[`ACS_STAT_BUSY] !== 1'b0 && n < 20);
		repeat (2) @(posedge pclk);
	endtask : order
	task automatic sense(input logic exp);
		order(acs_k_sen, `ACS_SENSE_EOS, 8'h00);
		apb(1'b0, `ACS_OFF_STAT, 32'h0);
		chk("sense", rd[`ACS_STAT_SENSE], exp);
	endtask : sense
	// busy held long enough to pass the two-stage sync
	task automatic conv();
		conv_busy <= 1'b1;
		repeat (4) @(posedge pclk);
		conv_busy <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask : conv
	task automatic final_report();
		$display("checks %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report
	// runaway guard, far above the 1400 or so cycles the tests need
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			final_report();
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		int i;
		logic [7:0] c;
		logic [7:0] fin;
		logic [5:0] dev;
		void'($urandom(32'haf7511e5));
		dev = 6'h20 | 6'($urandom_range(31));
		addr_strap = dev;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		chk("seq_mode", seq_mode, 1'b1);
		chk_sel(`ACS_FIRST_CH);
		repeat (4) @(posedge pclk);
		chk("addr_ok", addr_ok, 1'b1);
		apb(1'b1, `ACS_OFF_ADDR, {26'h0, dev});
		$display("test reset done");
		order(acs_k_exc, `ACS_FN_RANDOM, 8'h00);
		chk("seq_mode", seq_mode, 1'b0);
		for (i = 0; i < 10; i++) begin
			c = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
			order(acs_k_dto, 2'($urandom_range(2)), c);
			chk_sel(c);
		end
		apb(1'b0, `ACS_OFF_STAT, 32'h0);
		chk("settled", rd[`ACS_STAT_SETTLED], 1'b0);
		repeat (`ACS_SETTLE_CYC) @(posedge pclk);
		apb(1'b0, `ACS_OFF_STAT, 32'h0);
		chk("settled", rd[`ACS_STAT_SETTLED], 1'b1);
		apb(1'b1, `ACS_OFF_ADDR, {26'h0, dev ^ 6'h01});
		order(acs_k_dto, 2'h0, ~c);
		chk_sel(c);
		apb(1'b1, `ACS_OFF_ADDR, {26'h0, dev});
		order(acs_k_bic, 2'h2, ~c);
		chk_sel(c);
		apb(1'b0, 12'h00C, 32'h0);
		chk("pslverr", err, 1'b1);
		chk("prdata", rd, 32'h0);
		$display("test random done");
		fin = 8'($urandom_range(20, 2));
		order(acs_k_exc, `ACS_FN_SEQ, 8'h00);
		order(acs_k_dto, 2'h2, fin);
		sense(1'b0);
		for (i = 1; i <= fin; i++) begin
			chk_sel(8'(i));
			chk("eos_irq", eos_irq, i == fin);
			if (i < fin) conv();
		end
		sense(1'b1);
		chk("seq_mode", seq_mode, 1'b1);
		conv();
		chk_sel(8'h01);
		chk("eos_irq", eos_irq, 1'b0);
		$display("test sequential done");
		order(acs_k_exc, `ACS_FN_BIC, 8'h00);
		chk("bic_enabled", bic_enabled, 1'b1);
		chk("seq_mode", seq_mode, 1'b0);
		c = 8'($urandom);
		order(acs_k_bic, 2'h2, c);
		chk_sel(c);
		$display("test block transfer done");
		final_report();
	end
endmodule : analog_channel_sequencer_tb
`default_nettype wire
